// ==== rtl/adof_defines.svh ====
`ifndef ADOF_DEFINES_SVH
`define ADOF_DEFINES_SVH

// Sample word and counter widths
`define ADOF_SAMPLE_W        16
`define ADOF_CNT_W           8

// Clock rates in kHz
`define ADOF_SYS_CLK_KHZ     20000
`define ADOF_NAP_FREQ_KHZ    500
// Longest encode period before nap, rounded down to whole cycles
`define ADOF_NAP_CYC         (`ADOF_SYS_CLK_KHZ / `ADOF_NAP_FREQ_KHZ)

// Stabilizer lock, counted in encode cycles
`define ADOF_LOCK_EDGES      100

// Duty limits in percent
`define ADOF_DUTY_SCALE      100
`define ADOF_DCS_DUTY_MIN    10
`define ADOF_DCS_DUTY_MAX    90
`define ADOF_RAW_DUTY_MIN    45
`define ADOF_RAW_DUTY_MAX    55
// Period drift, in system cycles, still taken as the same frequency
`define ADOF_PER_TOL         1

// Output clock period in 45 degree steps
`define ADOF_PHASE_W         3
`define ADOF_PHASE_LAST      3'h7
`define ADOF_PHASE_HIGH_BIT  2

// Clock configuration register fields
`define ADOF_CLKCFG_DCS_BIT  0
`define ADOF_CLKCFG_DLY_LSB  1
`define ADOF_CLKCFG_DLY_MSB  2

// Output configuration register fields and codes
`define ADOF_OUTCFG_MODE_LSB 0
`define ADOF_OUTCFG_MODE_MSB 1
`define ADOF_MODE_CODE_DDRC  2'h1
`define ADOF_MODE_CODE_LVDS  2'h2

`endif

// ==== rtl/adof_fifo2.sv ====
`timescale 1ns/1ps
`default_nettype none

module adof_fifo2 #(
  parameter int WIDTH = 17
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  logic [WIDTH-1:0] mem_ff [2];
  logic             wr_ptr_ff;
  logic             rd_ptr_ff;
  logic [1:0]       count_ff;
  wire              push;
  wire              pop;

  assign in_ready_out  = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff ^ push;
      rd_ptr_ff <= rd_ptr_ff ^ pop;
      count_ff  <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// ==== rtl/adof_pkg.sv ====
package adof_pkg;

  typedef enum logic [1:0] {
    ADOF_MODE_FULL,
    ADOF_MODE_DDR_CMOS,
    ADOF_MODE_DDR_LVDS
  } adof_out_mode_e;

  typedef logic [1:0] adof_delay_t;

endpackage

// ==== rtl/adof_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module adof_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // First stage feeds only the second one
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/adof_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "adof_defines.svh"

module adof_top
  import adof_pkg::*;
#(
  parameter int SAMPLE_W = `ADOF_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_n_in,
  // Encode clock pins
  input  wire logic                  encode_clock_p_in,
  input  wire logic                  encode_clock_n_in,
  // Converter core sample
  input  wire logic [SAMPLE_W-1:0]   sample_in,
  input  wire logic                  sample_over_hi_in,
  input  wire logic                  sample_under_lo_in,
  // Configuration registers and pins
  input  wire logic [7:0]            clock_config_reg_in,
  input  wire logic [7:0]            output_config_reg_in,
  input  wire logic                  config_mode_select_in,
  input  wire logic                  par_cs_in,
  input  wire logic                  par_sck_in,
  // Output pins
  output logic [SAMPLE_W-1:0]        data_bus_out,
  output logic [SAMPLE_W/2-1:0]      ddr_lane_out,
  output logic [SAMPLE_W/2-1:0]      ddr_lane_n_out,
  output logic                       data_output_clock_out,
  output logic                       data_output_clock_n_out,
  output logic                       over_range_flag_out,
  output logic                       over_range_flag_n_out,
  // Status
  output logic                       ddr_mode_out,
  output logic                       lvds_mode_out,
  output logic                       nap_out,
  output logic                       dcs_enable_out,
  output logic                       dcs_locked_out,
  output logic                       encode_duty_fault_out,
  output logic                       sample_drop_out
);

  localparam int LANES = SAMPLE_W / 2;
  localparam int CW    = `ADOF_CNT_W;
  localparam int PW    = `ADOF_PHASE_W;

  // Synchronised pins
  logic [1:0]           enc_sync;
  logic [2:0]           cfg_sync;
  wire                  enc_lvl;
  wire                  par_mode;
  wire                  cs_lvl;
  wire                  sck_lvl;

  // Encode clock monitor
  logic                 enc_prev_ff;
  logic [CW-1:0]        idle_cnt_ff;
  logic [CW-1:0]        nxt_idle_cnt;
  logic [CW-1:0]        hi_cnt_ff;
  logic [CW-1:0]        per_last_ff;
  logic [CW-1:0]        lock_cnt_ff;
  logic [CW-1:0]        nxt_lock_cnt;
  logic                 nap_ff;
  logic                 locked_ff;
  logic                 duty_fault_ff;
  logic                 drop_ff;
  wire                  enc_rise;
  wire [CW-1:0]         per_now;
  wire                  freq_chg;
  wire                  lock_restart;
  wire [15:0]           hi_scaled;
  wire [15:0]           per_lo_lim;
  wire [15:0]           per_hi_lim;
  wire                  duty_bad;

  // Configuration
  wire                  dcs_on;
  wire [1:0]            mode_fld;
  adof_out_mode_e       mode_sel;
  adof_delay_t          dly_sel;

  // Buffer
  wire                  fifo_in_ready;
  wire                  fifo_out_valid;
  wire                  fifo_out_ready;
  wire [SAMPLE_W:0]     fifo_in_data;
  wire [SAMPLE_W:0]     fifo_out_data;

  // Output serializer
  logic [PW-1:0]        phase_ff;
  logic [SAMPLE_W-1:0]  word_ff;
  logic                 word_ovr_ff;
  adof_out_mode_e       mode_ff;
  adof_delay_t          dly_ff;
  logic [LANES-1:0]     lane_ff;
  logic [LANES-1:0]     lane_n_ff;
  logic [SAMPLE_W-1:0]  bus_ff;
  logic                 clk_ff;
  logic                 clk_n_ff;
  logic                 ovr_ff;
  logic                 ovr_n_ff;
  logic [LANES-1:0]     even_bits;
  logic [LANES-1:0]     odd_bits;
  wire                  word_end;
  wire                  ddr_on;
  wire                  lvds_on;
  wire                  odd_half;
  wire [PW-1:0]         clk_phase;
  wire                  nxt_clk;
  wire [LANES-1:0]      nxt_lane;

  adof_sync #(.WIDTH(2)) u_enc_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({encode_clock_n_in, encode_clock_p_in}),
    .sync_out   (enc_sync)
  );

  adof_sync #(.WIDTH(3)) u_cfg_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({par_sck_in, par_cs_in, config_mode_select_in}),
    .sync_out   (cfg_sync)
  );

  // Single-ended mode ties the complement low, so one term serves both
  assign enc_lvl  = enc_sync[0] & ~enc_sync[1];
  assign par_mode = cfg_sync[0];
  assign cs_lvl   = cfg_sync[1];
  assign sck_lvl  = cfg_sync[2];
  assign enc_rise = enc_lvl & ~enc_prev_ff;

  // Stabilizer and output mode selection
  assign dcs_on   = par_mode ? cs_lvl : clock_config_reg_in[`ADOF_CLKCFG_DCS_BIT];
  assign mode_fld = output_config_reg_in[`ADOF_OUTCFG_MODE_MSB:`ADOF_OUTCFG_MODE_LSB];
  assign mode_sel = par_mode ? (sck_lvl ? ADOF_MODE_DDR_LVDS : ADOF_MODE_FULL)
                  : (mode_fld == `ADOF_MODE_CODE_DDRC) ? ADOF_MODE_DDR_CMOS
                  : (mode_fld == `ADOF_MODE_CODE_LVDS) ? ADOF_MODE_DDR_LVDS
                  : ADOF_MODE_FULL;
  // Phase shift needs the stabilizer's clean half period
  assign dly_sel  = dcs_on ? clock_config_reg_in[`ADOF_CLKCFG_DLY_MSB:`ADOF_CLKCFG_DLY_LSB]
                  : adof_delay_t'(0);

  // Encode period and duty measurement
  assign per_now      = idle_cnt_ff + CW'(1);
  assign freq_chg     = (per_now > per_last_ff + CW'(`ADOF_PER_TOL)) || (per_last_ff > per_now + CW'(`ADOF_PER_TOL));
  assign hi_scaled    = 16'(hi_cnt_ff) * 16'(`ADOF_DUTY_SCALE);
  assign per_lo_lim   = 16'(per_now) * 16'(dcs_on ? `ADOF_DCS_DUTY_MIN : `ADOF_RAW_DUTY_MIN);
  assign per_hi_lim   = 16'(per_now) * 16'(dcs_on ? `ADOF_DCS_DUTY_MAX : `ADOF_RAW_DUTY_MAX);
  assign duty_bad     = (hi_scaled < per_lo_lim) || (hi_scaled > per_hi_lim);
  assign lock_restart = !dcs_on || nap_ff || (enc_rise && freq_chg);
  assign nxt_idle_cnt = enc_rise ? CW'(0)
                      : (idle_cnt_ff == CW'(`ADOF_NAP_CYC)) ? idle_cnt_ff
                      : idle_cnt_ff + CW'(1);
  assign nxt_lock_cnt = lock_restart ? CW'(0)
                      : (enc_rise && lock_cnt_ff != CW'(`ADOF_LOCK_EDGES)) ? lock_cnt_ff + CW'(1)
                      : lock_cnt_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      enc_prev_ff <= 1'b0;
      idle_cnt_ff <= '0;
      hi_cnt_ff   <= '0;
      per_last_ff <= '0;
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end else begin
      enc_prev_ff <= enc_lvl;
      idle_cnt_ff <= nxt_idle_cnt;
      hi_cnt_ff   <= enc_rise ? CW'(1) : hi_cnt_ff + CW'(enc_lvl && hi_cnt_ff != '1);
      per_last_ff <= enc_rise ? per_now : per_last_ff;
      lock_cnt_ff <= nxt_lock_cnt;
      locked_ff   <= (nxt_lock_cnt == CW'(`ADOF_LOCK_EDGES));
    end
  end

  // Nap on a stopped or too slow encode clock, left on the next edge
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      nap_ff        <= 1'b1;
      duty_fault_ff <= 1'b0;
      drop_ff       <= 1'b0;
    end else begin
      nap_ff        <= enc_rise ? 1'b0 : (idle_cnt_ff == CW'(`ADOF_NAP_CYC)) | nap_ff;
      duty_fault_ff <= (enc_rise && !nap_ff) ? duty_bad : duty_fault_ff;
      drop_ff       <= enc_rise && !fifo_in_ready;
    end
  end

  // One word per encode edge; flag rides in the same entry
  assign fifo_in_data   = {sample_over_hi_in | sample_under_lo_in, sample_in};
  assign word_end       = (phase_ff == `ADOF_PHASE_LAST);
  assign fifo_out_ready = word_end;

  adof_fifo2 #(.WIDTH(SAMPLE_W + 1)) u_buf (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (enc_rise),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  // Lane pairing
  always_comb begin
    even_bits = '0;
    odd_bits  = '0;
    for (int i = 0; i < LANES; i++) begin
      even_bits[i] = word_ff[2*i];
      odd_bits[i]  = word_ff[2*i+1];
    end
  end

  assign ddr_on    = (mode_ff != ADOF_MODE_FULL);
  assign lvds_on   = (mode_ff == ADOF_MODE_DDR_LVDS);
  assign odd_half  = phase_ff[`ADOF_PHASE_HIGH_BIT];
  assign nxt_lane  = ddr_on ? (odd_half ? odd_bits : even_bits) : '0;
  assign clk_phase = phase_ff - PW'(dly_ff);
  assign nxt_clk   = clk_phase[`ADOF_PHASE_HIGH_BIT];

  // Word, mode and delay change only at a period boundary: no period mixes two samples
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      phase_ff    <= '0;
      word_ff     <= '0;
      word_ovr_ff <= 1'b0;
      mode_ff     <= ADOF_MODE_FULL;
      dly_ff      <= '0;
    end else begin
      phase_ff <= phase_ff + PW'(1);
      if (word_end) begin
        mode_ff <= mode_sel;
        dly_ff  <= dly_sel;
        if (fifo_out_valid) begin
          word_ff     <= fifo_out_data[SAMPLE_W-1:0];
          word_ovr_ff <= fifo_out_data[SAMPLE_W];
        end
      end
    end
  end

  // Pins: clock and data registered together to keep their edges aligned
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      lane_ff   <= '0;
      lane_n_ff <= '0;
      bus_ff    <= '0;
      clk_ff    <= 1'b0;
      clk_n_ff  <= 1'b1;
      ovr_ff    <= 1'b0;
      ovr_n_ff  <= 1'b0;
    end else begin
      lane_ff   <= nxt_lane;
      lane_n_ff <= lvds_on ? ~nxt_lane : '0;
      bus_ff    <= ddr_on ? '0 : word_ff;
      clk_ff    <= nxt_clk;
      clk_n_ff  <= ~nxt_clk;
      ovr_ff    <= word_ovr_ff;
      ovr_n_ff  <= lvds_on & ~word_ovr_ff;
    end
  end

  assign data_bus_out            = bus_ff;
  assign ddr_lane_out            = lane_ff;
  assign ddr_lane_n_out          = lane_n_ff;
  assign data_output_clock_out   = clk_ff;
  assign data_output_clock_n_out = clk_n_ff;
  assign over_range_flag_out     = ovr_ff;
  assign over_range_flag_n_out   = ovr_n_ff;
  assign ddr_mode_out            = ddr_on;
  assign lvds_mode_out           = lvds_on;
  assign nap_out                 = nap_ff;
  assign dcs_enable_out          = dcs_on;
  assign dcs_locked_out          = locked_ff;
  assign encode_duty_fault_out   = duty_fault_ff;
  assign sample_drop_out         = drop_ff;

  AST_EVEN_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ddr_on && phase_ff >= 3'h1 && phase_ff <= 3'h4) |-> (lane_ff == even_bits))
    else $error("lanes not showing even bits in first half");
  AST_ODD_HIGH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ddr_on && phase_ff >= 3'h5) |-> (lane_ff == odd_bits))
    else $error("lanes not showing odd bits in second half");
  AST_EDGE_ALIGN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (ddr_on && dly_ff == 2'h0 && $stable(dly_ff) && phase_ff == 3'h5)
      |-> (clk_ff && !$past(clk_ff) && lane_ff == odd_bits))
    else $error("undelayed clock rise not with odd bit change");
  AST_CLK_DELAY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(clk_ff) |-> (phase_ff == 3'h5 + {1'b0, $past(dly_ff)}))
    else $error("output clock rise at wrong phase for delay");
  AST_DELAY_NEEDS_DCS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!dcs_on && word_end) |=> (dly_ff == 2'h0))
    else $error("clock delay active without stabilizer");
  AST_CLK_INVERSE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(clk_ff) |-> $fell(clk_n_ff) ##1 (clk_n_ff != clk_ff))
    else $error("complement clock not inverse");
  AST_FLAG_ALIGN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (phase_ff != 3'h0) |-> (ovr_ff == word_ovr_ff))
    else $error("over-range flag not aligned with its word");
  AST_NAP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (idle_cnt_ff == CW'(`ADOF_NAP_CYC) && !enc_rise) |=> nap_ff)
    else $error("no nap after encode clock stopped");
  AST_LOCK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(locked_ff) |-> (lock_cnt_ff == CW'(`ADOF_LOCK_EDGES) && $past(dcs_on)))
    else $error("stabilizer lock before one hundred cycles");
  AST_WORD_BOUNDARY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(word_ff) |-> (phase_ff == 3'h0))
    else $error("word changed inside an output clock period");
  AST_NO_PAR_DDRC: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (par_mode && word_end) |=> (mode_ff != ADOF_MODE_DDR_CMOS))
    else $error("DDR CMOS selected in parallel mode");

endmodule

`default_nettype wire

// ==== tb/adof_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module adof_rx_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Converter output pins
  input  wire logic [15:0] data_bus_in,
  input  wire logic [7:0]  ddr_lane_in,
  input  wire logic        data_output_clock_in,
  input  wire logic        over_range_flag_in,
  input  wire logic        ddr_mode_in,
  // Recovered words
  output logic             word_valid_out,
  output logic [16:0]      word_out
);
  logic [7:0]  lane_ff;
  logic [7:0]  even_ff;
  logic        clk_ff;
  logic        flag_ff;
  logic        ddr_ff;
  logic [15:0] ddr_word;
  wire         clk_rise = data_output_clock_in && !clk_ff;
  wire         clk_fall = !data_output_clock_in && clk_ff;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ddr_word[2*i]   = even_ff[i];
      ddr_word[2*i+1] = lane_ff[i];
    end
  end

  // Lanes move on the clock edge, so the level held just before each edge is taken
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      clk_ff         <= 1'b0;
      lane_ff        <= 8'h00;
      even_ff        <= 8'h00;
      flag_ff        <= 1'b0;
      ddr_ff         <= 1'b0;
      word_valid_out <= 1'b0;
      word_out       <= 17'h00000;
    end else begin
      clk_ff         <= data_output_clock_in;
      lane_ff        <= ddr_lane_in;
      flag_ff        <= over_range_flag_in;
      word_valid_out <= 1'b0;
      if (clk_rise) begin
        even_ff <= lane_ff;
        ddr_ff  <= ddr_mode_in;
      end
      if (clk_rise && !ddr_mode_in) begin
        word_valid_out <= 1'b1;
        word_out       <= {over_range_flag_in, data_bus_in};
      end
      // A period that straddles a mode change is not decoded
      if (clk_fall && ddr_ff && ddr_mode_in) begin
        word_valid_out <= 1'b1;
        word_out       <= {flag_ff, ddr_word};
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // Design pins
  logic        clk_sys_in, rst_n_in, encode_clock_p_in, encode_clock_n_in;
  logic [15:0] sample_in, data_bus_out;
  logic        sample_over_hi_in, sample_under_lo_in, config_mode_select_in, par_cs_in, par_sck_in;
  logic [7:0]  clock_config_reg_in, output_config_reg_in, ddr_lane_out, ddr_lane_n_out;
  logic        data_output_clock_out, data_output_clock_n_out, over_range_flag_out, over_range_flag_n_out;
  logic        ddr_mode_out, lvds_mode_out, nap_out, dcs_enable_out, dcs_locked_out;
  logic        encode_duty_fault_out, sample_drop_out, rx_valid;
  logic [16:0] rx_word;
  // Bench state
  int          n_errors = 0;
  int          checked = 0;
  int          seed = 32'hCC1C65EB;
  int          enc_on = 0;
  int          enc_hi = 200;
  int          enc_lo = 200;
  int          k, sent, matched, drops, nap_seen, fault_seen;
  logic        cmp_on = 1'b1;
  logic        edge_chk = 1'b1;
  logic        fix_on = 1'b0;
  logic        lock_chk = 1'b0;
  logic        nap_watch = 1'b0;
  logic        nap_chk = 1'b0;
  logic        clk_q, lvds_q;
  logic [7:0]  lane_q;
  logic [16:0] last_rx = 17'h00000;
  logic [16:0] expq[$];

  adof_top u_adof_top (.clk_sys_in, .rst_n_in, .encode_clock_p_in, .encode_clock_n_in, .sample_in,
    .sample_over_hi_in, .sample_under_lo_in, .clock_config_reg_in, .output_config_reg_in,
    .config_mode_select_in, .par_cs_in, .par_sck_in, .data_bus_out, .ddr_lane_out, .ddr_lane_n_out,
    .data_output_clock_out, .data_output_clock_n_out, .over_range_flag_out, .over_range_flag_n_out,
    .ddr_mode_out, .lvds_mode_out, .nap_out, .dcs_enable_out, .dcs_locked_out, .encode_duty_fault_out,
    .sample_drop_out);

  adof_rx_model u_adof_rx_model (.clk_sys_in, .rst_n_in, .data_bus_in(data_bus_out),
    .ddr_lane_in(ddr_lane_out), .data_output_clock_in(data_output_clock_out),
    .over_range_flag_in(over_range_flag_out), .ddr_mode_in(ddr_mode_out),
    .word_valid_out(rx_valid), .word_out(rx_word));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask

  task automatic set_cfg(input logic dcs, input logic [1:0] dly, input logic [1:0] mode);
    clock_config_reg_in = {5'h00, dly, dcs};
    output_config_reg_in = {6'h00, mode};
    cyc(24);
  endtask

  // Encode runs within a burst and stands still low once the burst ends
  task automatic run_stream(input int n, input int hi, input int lo);
    int i;
    expq.delete();
    sent = 0; matched = 0; drops = 0; nap_seen = 0; fault_seen = 0;
    enc_hi = hi; enc_lo = lo; enc_on = 1;
    for (i = 0; i < 4000 && sent < n; i++) cyc(1);
    enc_on = 0;
    nap_chk = 1'b0;
    if (sent < n) begin
      n_errors++;
      give_verdict();
    end
    cyc(60);
  endtask

  // Cycles from the lanes turning to odd bits until the output clock rises
  task automatic meas_dly(input int d);
    int c, i;
    logic [7:0] lp;
    logic cp;
    c = -1;
    lp = ddr_lane_out;
    cp = data_output_clock_out;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      if (ddr_lane_out === 8'hFF && lp !== 8'hFF) c = 0;
      else if (c >= 0) c++;
      if (c >= 0 && data_output_clock_out === 1'b1 && cp === 1'b0) break;
      lp = ddr_lane_out;
      cp = data_output_clock_out;
    end
    if (i == 40) begin
      n_errors++;
      give_verdict();
    end
    chk("clk_delay", c, d);
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    encode_clock_p_in = 1'b0;
    #13;
    forever begin
      if (enc_on != 0) begin
        encode_clock_p_in = 1'b1;
        #(enc_hi);
        encode_clock_p_in = 1'b0;
        #(enc_lo);
      end else #25;
    end
  end

  // A new core word for each encode rise, settled before the design captures it
  always @(posedge encode_clock_p_in) begin
    @(posedge clk_sys_in);
    #2;
    sample_in = fix_on ? 16'hAAAA : 16'($random(seed));
    sample_over_hi_in = ($random(seed) & 3) == 0;
    sample_under_lo_in = ($random(seed) & 3) == 0;
    expq.push_back({sample_over_hi_in | sample_under_lo_in, sample_in});
    sent++;
    if (lock_chk && sent == 97) chk("locked_early", dcs_locked_out, 0);
    if (lock_chk && sent == 104) chk("locked", dcs_locked_out, 1);
    if (nap_watch && sent == 2) nap_chk = 1'b1;
  end

  always @(negedge clk_sys_in) begin
    int idx;
    if (rst_n_in === 1'b1) begin
      chk("clock_n", data_output_clock_n_out, !data_output_clock_out);
      // Pins follow the mode status one cycle late, so both samples must be LVDS
      if (lvds_mode_out === 1'b1 && lvds_q === 1'b1) begin
        chk("lane_n", ddr_lane_n_out, 8'(~ddr_lane_out));
        chk("flag_n", over_range_flag_n_out, !over_range_flag_out);
      end
      if (edge_chk && ddr_mode_out === 1'b1 && ddr_lane_out !== lane_q) begin
        chk("lane_edge", data_output_clock_out !== clk_q, 1);
      end
      if (nap_chk) chk("nap_awake", nap_out, 0);
      // Only naps while the encode still runs count, not the one after it stops
      if (sent >= 2 && enc_on != 0 && nap_out === 1'b1) nap_seen++;
      if (sent >= 2 && encode_duty_fault_out === 1'b1) fault_seen++;
      if (sample_drop_out === 1'b1) drops++;
      if (rx_valid === 1'b1 && rx_word !== last_rx) begin
        last_rx = rx_word;
        idx = -1;
        foreach (expq[i]) if (idx < 0 && expq[i] === rx_word) idx = i;
        if (idx >= 0) begin
          repeat (idx + 1) void'(expq.pop_front());
          matched++;
        end else if (cmp_on) chk("rx_word_sent", 0, 1);
      end
    end
    lane_q = ddr_lane_out;
    clk_q = data_output_clock_out;
    lvds_q = lvds_mode_out;
  end

  initial begin
    rst_n_in = 1'b0;
    encode_clock_n_in = 1'b0;
    sample_in = 16'h0000; sample_over_hi_in = 1'b0; sample_under_lo_in = 1'b0;
    clock_config_reg_in = 8'h00; output_config_reg_in = 8'h00;
    config_mode_select_in = 1'b0; par_cs_in = 1'b0; par_sck_in = 1'b0;
    cyc(16);
    chk("rst_clk", data_output_clock_out, 0);
    chk("rst_clk_n", data_output_clock_n_out, 1);
    chk("rst_nap", nap_out, 1);
    chk("rst_lock", dcs_locked_out, 0);
    chk("rst_mode", ddr_mode_out, 0);
    rst_n_in = 1'b1;
    cyc(4);
    for (k = 0; k < 4; k++) begin
      set_cfg(1'b0, 2'h0, k[1:0]);
      run_stream(12, 200, 200);
      chk("mode_ddr", ddr_mode_out, k == 1 || k == 2);
      chk("mode_lvds", lvds_mode_out, k == 2);
      chk("mode_words", matched, 12);
      chk("mode_drops", drops, 0);
      chk("duty_half", fault_seen, 0);
    end
    config_mode_select_in = 1'b1;
    for (k = 0; k < 2; k++) begin
      par_sck_in = k[0];
      par_cs_in = !k[0];
      clock_config_reg_in = {7'h00, k[0]};
      output_config_reg_in = 8'h01;
      run_stream(12, 200, 200);
      chk("par_lvds", lvds_mode_out, k[0]);
      chk("par_ddr", ddr_mode_out, k[0]);
      chk("par_dcs", dcs_enable_out, !k[0]);
      chk("par_words", matched, 12);
    end
    config_mode_select_in = 1'b0;
    set_cfg(1'b1, 2'h0, 2'h1);
    chk("ser_dcs", dcs_enable_out, 1);
    lock_chk = 1'b1;
    run_stream(110, 200, 200);
    lock_chk = 1'b0;
    chk("lock_words", matched, 110);
    run_stream(20, 120, 380);
    chk("duty_dcs", fault_seen, 0);
    chk("duty_words", matched, 20);
    set_cfg(1'b0, 2'h0, 2'h1);
    chk("unlock", dcs_locked_out, 0);
    run_stream(20, 120, 380);
    chk("duty_raw", fault_seen > 0, 1);
    set_cfg(1'b1, 2'h0, 2'h1);
    run_stream(16, 100, 100);
    chk("burst_drop", drops > 0, 1);
    chk("burst_words", matched + drops, 16);
    chk("nap_stop", nap_out, 1);
    // Stabilizer kept off for every rate below 2 Msps
    set_cfg(1'b0, 2'h0, 2'h0);
    nap_watch = 1'b1;
    run_stream(6, 750, 750);
    nap_watch = 1'b0;
    run_stream(4, 1100, 1100);
    chk("nap_slow", nap_seen > 0, 1);
    cmp_on = 1'b0; edge_chk = 1'b0; fix_on = 1'b1;
    enc_hi = 200; enc_lo = 200; enc_on = 1;
    for (k = 0; k < 8; k++) begin
      set_cfg(k[2], k[1:0], 2'h1);
      meas_dly(k[2] ? (k & 3) : 0);
    end
    enc_on = 0;
    fix_on = 1'b0;
    set_cfg(1'b0, 2'h0, 2'h1);
    cyc(60);
    cmp_on = 1'b1; edge_chk = 1'b1;
    run_stream(8, 200, 200);
    chk("end_words", matched, 8);
    give_verdict();
  end
endmodule

`default_nettype wire
